// *** branch_call_bit_toggle_exec.sv ***
// branch_call_bit_toggle_exec: executes toggle, two branches and the two-word call
// assumes the fetch stage presents instr_i for a whole instruction cycle and
// the data memory returns mem_rdata_i within Q3 for the address registered in Q2 and shown from Q3
// and that the core owns every status flag; this block only reads them
// What this block does
// - toggle inverts one selected bit, opcode 0111
// - branch on zero when zero flag set
// - taken target is PC plus 2 plus 2n
// - branch takes one cycle, two when taken
// - decode, read literal, compute, write PC Q4
// - branch on overflow when overflow flag set
// - call pushes own address plus 4
// - call spans two words, 2-Mbyte space
// - call loads PC bits 20:1, two cycles
// - save bit copies W, status, bank to shadows
`timescale 1ns/10ps
`default_nettype none
module branch_call_bit_toggle_exec (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] instr_i,
  input wire logic [exec_pkg::PC_W-1:0] pc_i,
  input wire exec_pkg::core_regs_t regs_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [1:0] phase_o,
  output logic [7:0] mem_raddr_o,
  output logic mem_rbank_o,
  output exec_pkg::mem_wr_t mem_wr_o,
  output logic pc_load_o,
  output logic [exec_pkg::PC_W-1:0] pc_new_o,
  output exec_pkg::stack_push_t push_o,
  output exec_pkg::core_regs_t shadow_o,
  output logic nop_cycle_o
);
  import exec_pkg::*;

  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                    input logic [7:0] n);
    logic [PC_W-1:0] off;
    off = {{(PC_W-9){n[7]}}, n, 1'b0};
    branch_target = pc + PC_STEP + off;
  endfunction

  // one-hot mask of the bit named by the toggle's 3-bit field
  function automatic logic [7:0] toggle_mask(input logic [2:0] b);
    toggle_mask = 8'h01 << b;
  endfunction

  // 20-bit word target from both call words; bit 0 of a byte PC stays clear
  function automatic logic [PC_W-1:0] call_target(input logic [11:0] hi,
                                                  input logic [7:0] lo);
    call_target = {hi, lo, 1'b0};
  endfunction

  logic [1:0] phase;
  q_phase_gen u_phase (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .phase_o(phase)
  );

  exec_state_t state_ff, nxt_state;
  logic [7:0] lit_ff, nxt_lit;
  logic [7:0] data_ff, nxt_data;
  logic take_ff, nxt_take;
  logic save_ff, nxt_save;
  logic [PC_W-1:0] ret_ff, nxt_ret;
  logic [1:0] phase_ff;
  logic [7:0] raddr_ff, nxt_raddr;
  logic rbank_ff, nxt_rbank;
  mem_wr_t wr_ff, nxt_wr;
  logic pcld_ff, nxt_pcld;
  logic [PC_W-1:0] pcnew_ff, nxt_pcnew;
  stack_push_t push_ff, nxt_push;
  core_regs_t shadow_ff, nxt_shadow;
  logic nop_ff, nxt_nop;

  logic is_toggle, is_bz, is_bov, is_call;
  logic is_branch;
  assign is_toggle = instr_i[15:12] == OPC_TOGGLE;
  assign is_bz = instr_i[15:8] == OPC_BR_ZERO;
  assign is_bov = instr_i[15:8] == OPC_BR_OVF;
  assign is_call = instr_i[15:9] == OPC_CALL_HI;
  assign is_branch = is_bz || is_bov;

  always_comb begin
    nxt_state = state_ff;
    nxt_lit = lit_ff;
    nxt_data = data_ff;
    nxt_take = take_ff;
    nxt_save = save_ff;
    nxt_ret = ret_ff;
    nxt_raddr = raddr_ff;
    nxt_rbank = rbank_ff;
    nxt_wr = '0;
    nxt_pcld = 1'b0;
    nxt_pcnew = pcnew_ff;
    nxt_push = '0;
    nxt_shadow = shadow_ff;
    nxt_nop = nop_ff;
    // status is only read here, never driven back to the core
    case (state_ff)
      ST_EXEC: begin
        case (phase)
          Q1: begin
            nxt_nop = 1'b0;
            // flags sampled in Q1 so a later flag change cannot flip a decided branch
            nxt_take = (is_bz && regs_i.status[STATUS_Z])
              || (is_bov && regs_i.status[STATUS_OV]);
            nxt_save = instr_i[8];
            nxt_ret = pc_i + RET_OFFSET;
          end
          Q2: begin
            nxt_lit = instr_i[7:0];
            nxt_raddr = instr_i[7:0];
            nxt_rbank = instr_i[8];
          end
          Q3: begin
            if (is_toggle) begin
              nxt_data = mem_rdata_i ^ toggle_mask(instr_i[11:9]);
            end
            // pc_new_o only moves for a branch or a call's second word, so it keeps showing the last target
            if (is_branch) begin
              nxt_pcnew = branch_target(pc_i, lit_ff);
            end
            if (is_call) begin
              // pushed in Q3 so the return address is on the stack before the PC moves
              nxt_push.push = 1'b1;
              nxt_push.addr = ret_ff;
            end
          end
          Q4: begin
            if (is_toggle) begin
              nxt_wr.we = 1'b1;
              nxt_wr.addr = raddr_ff;
              nxt_wr.bank_sel = rbank_ff;
              nxt_wr.data = data_ff;
            end
            if (is_branch && take_ff) begin
              nxt_pcld = 1'b1;
              nxt_state = ST_FLUSH;
            end
            if (is_call) begin
              if (save_ff) begin
                nxt_shadow = regs_i;
              end
              nxt_state = ST_CALL2;
            end
          end
          default: nxt_state = ST_EXEC;
        endcase
      end
      ST_FLUSH: begin
        // the word fetched behind a taken branch is thrown away
        nxt_nop = 1'b1;
        if (phase == Q4) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_CALL2: begin
        nxt_nop = 1'b1;
        if (phase == Q4) begin
          // a second word without the 1111 prefix loads nothing; the return
          // address already pushed stays on the stack
          if (instr_i[15:12] == OPC_CALL_W2) begin
            nxt_pcld = 1'b1;
            nxt_pcnew = call_target(instr_i[11:0], lit_ff);
          end
          nxt_state = ST_EXEC;
        end
      end
      default: nxt_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_EXEC;
      lit_ff <= 8'h00;
      data_ff <= 8'h00;
      take_ff <= 1'b0;
      save_ff <= 1'b0;
      ret_ff <= '0;
      phase_ff <= Q1;
      raddr_ff <= 8'h00;
      rbank_ff <= 1'b0;
      wr_ff <= '0;
      pcld_ff <= 1'b0;
      pcnew_ff <= '0;
      push_ff <= '0;
      shadow_ff <= '0;
      nop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lit_ff <= nxt_lit;
      data_ff <= nxt_data;
      take_ff <= nxt_take;
      save_ff <= nxt_save;
      ret_ff <= nxt_ret;
      phase_ff <= phase;
      raddr_ff <= nxt_raddr;
      rbank_ff <= nxt_rbank;
      wr_ff <= nxt_wr;
      pcld_ff <= nxt_pcld;
      pcnew_ff <= nxt_pcnew;
      push_ff <= nxt_push;
      shadow_ff <= nxt_shadow;
      nop_ff <= nxt_nop;
    end
  end

  assign phase_o = phase_ff;
  assign mem_raddr_o = raddr_ff;
  assign mem_rbank_o = rbank_ff;
  assign mem_wr_o = wr_ff;
  assign pc_load_o = pcld_ff;
  assign pc_new_o = pcnew_ff;
  assign push_o = push_ff;
  assign shadow_o = shadow_ff;
  assign nop_cycle_o = nop_ff;
endmodule
`default_nettype wire

// *** exec_pkg.sv ***
// exec_pkg: encodings, field positions and carriers for the branch/call/toggle executor
// assumes 16-bit instruction words and a 21-bit byte program counter
package exec_pkg;
  localparam int PC_W = 21;
  localparam logic [3:0] OPC_TOGGLE = 4'h7;
  localparam logic [7:0] OPC_BR_ZERO = 8'he0;
  localparam logic [7:0] OPC_BR_OVF = 8'he4;
  localparam logic [6:0] OPC_CALL_HI = 7'h76;
  localparam logic [3:0] OPC_CALL_W2 = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] RET_OFFSET = 21'h000004;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  localparam int STATUS_Z = 2;
  localparam int STATUS_OV = 3;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_FLUSH = 2'b01,
    ST_CALL2 = 2'b10
  } exec_state_t;

  typedef struct packed {
    logic [7:0] wreg;
    logic [7:0] status;
    logic [3:0] bank;
  } core_regs_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic bank_sel;
    logic [7:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic push;
    logic [PC_W-1:0] addr;
  } stack_push_t;
endpackage

// *** exec_sva.sv ***
// exec_sva: port checks for the branch/call/toggle executor
// assumes bind onto branch_call_bit_toggle_exec; load and write pulses seen one clock after Q4, push one clock after Q3
`timescale 1ns/10ps
`default_nettype none
module exec_sva
  import exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] instr_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire core_regs_t regs_i,
  input wire logic [7:0] mem_rdata_i,
  input wire mem_wr_t mem_wr_o,
  input wire logic pc_load_o,
  input wire logic [PC_W-1:0] pc_new_o,
  input wire stack_push_t push_o,
  input wire core_regs_t shadow_o,
  input wire logic nop_cycle_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [PC_W-1:0] br_tgt;
  logic is_bz, is_bov;
  assign br_tgt = pc_i + PC_STEP + {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
  assign is_bz = instr_i[15:8] == OPC_BR_ZERO;
  assign is_bov = instr_i[15:8] == OPC_BR_OVF;
  toggle_data_a: assert property (mem_wr_o.we |-> $past(instr_i[15:12], 2) == OPC_TOGGLE &&
    (mem_wr_o.data ^ $past(mem_rdata_i, 2)) == (8'h01 << $past(instr_i[11:9], 2)))
    else $error("toggle write wrong");
  br_target_a: assert property (pc_load_o && $past(is_bz | is_bov, 2) |->
    pc_new_o == $past(br_tgt, 2)) else $error("branch target wrong");
  bz_flag_a: assert property (pc_load_o && $past(is_bz, 2) |->
    $past(regs_i.status[STATUS_Z], 2)) else $error("zero branch without flag");
  bov_flag_a: assert property (pc_load_o && $past(is_bov, 2) |->
    $past(regs_i.status[STATUS_OV], 2)) else $error("overflow branch without flag");
  br_flush_a: assert property (pc_load_o && $past(is_bz | is_bov, 2) |->
    ##1 nop_cycle_o) else $error("no flush after branch");
  ret_push_a: assert property (push_o.push |-> push_o.addr == $past(pc_i) + RET_OFFSET)
    else $error("return address wrong");
  call_load_a: assert property (push_o.push |-> ##[1:6] pc_load_o)
    else $error("call never loads");
  call_tgt_a: assert property (pc_load_o && $past(instr_i[15:12], 2) == OPC_CALL_W2 |->
    pc_new_o == {$past(instr_i[11:0], 2), $past(instr_i[7:0], 6), 1'b0})
    else $error("call target wrong");
  shadow_save_a: assert property ($changed(shadow_o) |->
    $past(instr_i[15:8], 2) == {OPC_CALL_HI, 1'b1}) else $error("shadow changed");
endmodule
bind branch_call_bit_toggle_exec exec_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .instr_i(instr_i), .pc_i(pc_i), .regs_i(regs_i), .mem_rdata_i(mem_rdata_i),
  .mem_wr_o(mem_wr_o), .pc_load_o(pc_load_o), .pc_new_o(pc_new_o), .push_o(push_o),
  .shadow_o(shadow_o), .nop_cycle_o(nop_cycle_o));
`default_nettype wire

// *** q_phase_gen.sv ***
// q_phase_gen: four-phase instruction-cycle sequencer
// assumes one core clock; Q4 is the one-clock phase code closing each instruction cycle
`timescale 1ns/10ps
`default_nettype none
module q_phase_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [1:0] phase_o
);
  import exec_pkg::*;
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;

  always_comb begin
    nxt_phase = phase_ff + 2'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign phase_o = phase_ff;
endmodule
`default_nettype wire

// *** tb_branch_call_bit_toggle_exec.sv ***
// tb_branch_call_bit_toggle_exec: directed tests of toggle, both branches and call
// assumes one instruction word per four clocks, first Q1 on the edge after reset
`timescale 1ns/10ps
`default_nettype none
module tb_branch_call_bit_toggle_exec;
  import exec_pkg::*;
  logic clk_i = 0, rst_n_i = 0;
  logic [15:0] instr_i = 16'h0000;
  logic [PC_W-1:0] pc_i = 21'h000000, got_pc, got_push;
  core_regs_t regs_i = '0, shadow_o;
  logic [7:0] mem_rdata_i = 8'h00, mem_raddr_o;
  logic [1:0] phase_o;
  logic mem_rbank_o, pc_load_o, nop_cycle_o;
  mem_wr_t mem_wr_o, wr;
  stack_push_t push_o;
  int n_fail = 0, total_checks = 0, n_load, n_wr, n_nop, n_q2, cycles = 0;
  logic [8:0] got_rd;
  logic [PC_W-1:0] pc_new_o_w;
  branch_call_bit_toggle_exec uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .pc_i(pc_i), .regs_i(regs_i), .mem_rdata_i(mem_rdata_i), .phase_o(phase_o),
    .mem_raddr_o(mem_raddr_o), .mem_rbank_o(mem_rbank_o), .mem_wr_o(mem_wr_o),
    .pc_load_o(pc_load_o), .pc_new_o(pc_new_o_w), .push_o(push_o), .shadow_o(shadow_o),
    .nop_cycle_o(nop_cycle_o));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (pc_load_o === 1'b1) begin n_load++; got_pc = pc_new_o_w; end
    if (mem_wr_o.we === 1'b1) begin n_wr++; wr = mem_wr_o; end
    if (push_o.push === 1'b1) got_push = push_o.addr;
    if (nop_cycle_o === 1'b1) n_nop++;
    // read address of the first word, seen while the delayed phase shows Q2
    if (phase_o === Q2) begin
      if (n_q2 == 0) got_rd = {mem_rbank_o, mem_raddr_o};
      n_q2++;
    end
    if (cycles == 2000) begin n_fail++; stop_test(); end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin n_fail++; $display("[FAIL] %0t %s", $time, m); end
  endtask
  // one word, a second word, then an idle word, so delayed pulses land inside the capture
  task automatic run(input logic [15:0] w, input logic [15:0] w2);
    n_load = 0; n_wr = 0; n_nop = 0;
    n_q2 = 0;
    instr_i = w; repeat (4) @(posedge clk_i); #1;
    instr_i = w2; repeat (4) @(posedge clk_i); #1;
    instr_i = 16'h0000; repeat (4) @(posedge clk_i); #1;
  endtask
  task automatic t_toggle();
    mem_rdata_i = 8'h75;
    run(16'h7882, 16'h0000);
    chk(n_wr == 1 && wr.data === 8'h65 && wr.addr === 8'h82 && !wr.bank_sel, "toggle");
    chk(n_q2 == 3 && got_rd === 9'h082, "toggle read address");
    run(16'h7fff, 16'h0000);
    chk(n_wr == 1 && wr.data === 8'hf5 && wr.addr === 8'hff && wr.bank_sel, "toggle bit 7");
    chk(got_rd === 9'h1ff, "toggle banked read");
    $display("toggle test ended");
  endtask
  task automatic t_branch();
    pc_i = 21'h001000; regs_i.status = 8'h04;
    run(16'he080, 16'h0000);
    chk(n_load == 1 && got_pc === 21'h000f02 && n_nop == 4, "zero taken");
    regs_i.status = 8'h08;
    run(16'he080, 16'h0000);
    chk(n_load == 0 && n_nop == 0, "zero not taken");
    pc_i = 21'h1ffff0;
    run(16'he47f, 16'h0000);
    chk(n_load == 1 && got_pc === 21'h0000f0, "overflow taken");
    regs_i.status = 8'h04;
    run(16'he47f, 16'h0000);
    chk(n_load == 0 && n_wr == 0, "overflow not taken");
    $display("branch test ended");
  endtask
  task automatic t_call();
    pc_i = 21'h000100; regs_i = {8'h5a, 8'h1c, 4'h9};
    run(16'hedde, 16'hfabc);
    chk(got_push === 21'h000104 && got_pc === 21'h1579bc, "call target");
    chk(shadow_o === regs_i && n_load == 1 && n_nop == 4, "shadow save");
    regs_i = {8'h33, 8'h00, 4'h2};
    run(16'hec12, 16'hf001);
    chk(got_pc === 21'h000224 && n_load == 1 && shadow_o === 20'h5a1c9, "call no save");
    $display("call test ended");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_n_i = 1;
    t_toggle();
    t_branch();
    t_call();
    stop_test();
  end
endmodule
`default_nettype wire
